//--- design/touch_baseline_config_regs.sv
/*
 * Configuration register bank for a one- or two-sensor touch controller:
 * baseline tracking settings, raw-count filtering, per-sensor scan order,
 * touch thresholds, excitation currents and the keyed slave-address guard.
 * Holds one baseline tracker per present sensor.
 * Assumes the serial-bus slave on clk hands over byte accesses as a one-cycle
 * write or read strobe with address, and that the analog core supplies raw
 * counts on clk. Noise and bucket limits come from registers kept elsewhere.
 */
`timescale 1ns/10ps
`include "touch_consts.svh"
module touch_baseline_config_regs #(
    parameter int NUM_SENSORS = 2
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // register access from the serial-bus slave
    input  wire logic             reg_write,
    input  wire logic             reg_read,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    output logic      [7:0]       reg_rdata,
    // device mode and serial-bus activity
    input  wire logic             setup_mode,
    input  wire logic             bus_active,
    // shared limits held by neighbouring registers
    input  wire logic [7:0]       noise_limit,
    input  wire logic [7:0]       bucket_limit,
    // sensing core samples
    input  wire logic [1:0][15:0] raw_count,
    input  wire logic [1:0]       sample_valid,
    // settings to the sensing core
    output logic      [1:0]       scan_order,
    output logic      [1:0][7:0]  touch_threshold,
    output logic      [1:0][7:0]  excitation_current,
    output logic      [1:0][15:0] baseline,
    // slave address to the bus slave
    output logic      [7:0]       slave_address_register,
    output logic                  address_guard_state
);
    touch_pkg::regs_state_t r;
    touch_pkg::regs_state_t next_r;

    // per-sensor presence mask; the second sensor is absent in the single build
    logic [1:0] present;

    // write strobes per register
    logic wr_neg;
    logic wr_low;
    logic wr_flt;
    logic wr_guard;
    logic wr_addr;

    // sensor availability decode
    assign present[0] = 1'b1;
    assign present[1] = (NUM_SENSORS > 1);

    // shared register write decode
    assign wr_neg   = reg_write && (reg_addr == `OFF_NEG_NOISE);
    assign wr_low   = reg_write && (reg_addr == `OFF_LOW_RESET);
    assign wr_flt   = reg_write && (reg_addr == `OFF_FILTER);
    assign wr_guard = reg_write && (reg_addr == `OFF_GUARD);
    assign wr_addr  = reg_write && (reg_addr == `OFF_SLAVE_ADDR);

    // outputs straight from the state register
    assign reg_rdata              = r.rdata;
    assign scan_order             = r.scan;
    assign touch_threshold        = r.thresh;
    assign excitation_current     = r.current;
    assign slave_address_register = r.addr_active;
    assign address_guard_state    = r.guard;

    // register writes, guard sequence and read data
    always_comb begin
        logic [7:0] rd;
        rd     = 8'h00;
        next_r = r;

        // forced baseline reset is a one-cycle pulse; bit 7 never stores
        next_r.force_reset = wr_flt && reg_wdata[`FLT_FORCE_BIT];

        if (wr_neg) begin
            next_r.neg_noise = reg_wdata;
        end
        if (wr_low) begin
            next_r.low_reset = reg_wdata;
        end
        if (wr_flt) begin
            next_r.filter = reg_wdata & `FLT_WRITE_MASK;
        end

        // per-sensor scan order, threshold and excitation current
        for (int i = 0; i < 2; i++) begin
            if (present[i] && reg_write) begin
                if (reg_addr == 8'(`OFF_SCAN0 + i) && setup_mode) begin
                    next_r.scan[i] = reg_wdata[0];
                end
                if (reg_addr == 8'(`OFF_THRESH0 + i)) begin
                    next_r.thresh[i] = reg_wdata;
                end
                if (reg_addr == 8'(`OFF_CURRENT0 + i)) begin
                    // zero falls back to the default current
                    next_r.current[i] = (reg_wdata == 8'h00) ? `CURRENT_DEFAULT : reg_wdata;
                end
            end
        end

        // keyed guard sequence; any wrong byte restarts the match
        if (wr_guard) begin
            unique case (r.seq)
                touch_pkg::seq_unlock1: begin
                    next_r.seq = (reg_wdata == `KEY_UNLOCK_1) ? touch_pkg::seq_unlock2 : touch_pkg::seq_idle;
                end
                touch_pkg::seq_unlock2: begin
                    next_r.seq = touch_pkg::seq_idle;
                    if (reg_wdata == `KEY_UNLOCK_2) begin
                        next_r.guard = 1'b0;
                    end
                end
                touch_pkg::seq_lock1: begin
                    next_r.seq = (reg_wdata == `KEY_LOCK_1) ? touch_pkg::seq_lock2 : touch_pkg::seq_idle;
                end
                touch_pkg::seq_lock2: begin
                    next_r.seq = touch_pkg::seq_idle;
                    if (reg_wdata == `KEY_LOCK_2) begin
                        next_r.guard       = 1'b1;
                        next_r.addr_active = r.addr_pending;
                    end
                end
                default: begin
                    next_r.seq = touch_pkg::seq_idle;
                end
            endcase
            // a first key byte always starts a fresh sequence
            if (reg_wdata == `KEY_UNLOCK_0) begin
                next_r.seq = touch_pkg::seq_unlock1;
            end else if (reg_wdata == `KEY_LOCK_0) begin
                next_r.seq = touch_pkg::seq_lock1;
            end
            if (r.seq == touch_pkg::seq_unlock2 && reg_wdata == `KEY_UNLOCK_2) begin
                next_r.seq = touch_pkg::seq_idle;
            end
            if (r.seq == touch_pkg::seq_lock2 && reg_wdata == `KEY_LOCK_2) begin
                next_r.seq = touch_pkg::seq_idle;
            end
        end

        // new slave address is only staged, and only while unlocked
        if (wr_addr && !r.guard) begin
            next_r.addr_pending = reg_wdata;
        end

        // read data mux; unmapped or absent offsets read zero
        unique case (reg_addr)
            `OFF_NEG_NOISE:  rd = r.neg_noise;
            `OFF_LOW_RESET:  rd = r.low_reset;
            `OFF_FILTER:     rd = r.filter;
            `OFF_SCAN0:      rd = {7'h00, r.scan[0]};
            `OFF_SCAN1:      rd = present[1] ? {7'h00, r.scan[1]} : 8'h00;
            `OFF_THRESH0:    rd = r.thresh[0];
            `OFF_THRESH1:    rd = present[1] ? r.thresh[1] : 8'h00;
            `OFF_CURRENT0:   rd = r.current[0];
            `OFF_CURRENT1:   rd = present[1] ? r.current[1] : 8'h00;
            `OFF_GUARD:      rd = {7'h00, r.guard};
            `OFF_SLAVE_ADDR: rd = r.addr_pending;
            default:         rd = 8'h00;
        endcase
        if (reg_read) begin
            next_r.rdata = rd;
        end
    end

    // state register with documented reset values
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r.neg_noise    <= `RST_NEG_NOISE;
            r.low_reset    <= `RST_LOW_RESET;
            r.filter       <= `RST_FILTER;
            r.force_reset  <= 1'b0;
            r.scan         <= {2{`RST_SCAN}};
            r.thresh       <= {2{`RST_THRESH}};
            r.current      <= {2{`RST_CURRENT}};
            r.guard        <= `RST_GUARD;
            r.seq          <= touch_pkg::seq_idle;
            r.addr_pending <= `RST_SLAVE_ADDR;
            r.addr_active  <= `RST_SLAVE_ADDR;
            r.rdata        <= 8'h00;
        end else begin
            r <= next_r;
        end
    end

    // one tracker per present sensor; absent sensor baseline reads zero
    for (genvar g = 0; g < 2; g++) begin : g_sensor
        if (g < NUM_SENSORS) begin : g_on
            track_if tif ();

            // shared settings to this sensor's tracker
            assign tif.noise_limit              = noise_limit;
            assign tif.negative_noise_limit     = r.neg_noise;
            assign tif.low_sample_reset_count   = r.low_reset;
            assign tif.bucket_limit             = bucket_limit;
            assign tif.force_baseline_reset     = r.force_reset;
            assign tif.bus_activity_sample_drop = r.filter[`FLT_DROP_BIT];
            assign tif.avg_enable               = r.filter[`FLT_AVG_BIT];
            assign tif.avg_order                = r.filter[1:0];
            assign baseline[g]                  = tif.baseline;

            baseline_tracker u_tracker (
                .clk          (clk),
                .rst          (rst),
                .tif          (tif),
                .raw_count    (raw_count[g]),
                .sample_valid (sample_valid[g]),
                .bus_active   (bus_active)
            );
        end else begin : g_off
            assign baseline[g] = 16'h0000;
        end
    end
endmodule

//--- design/touch_consts.svh
/*
 * Register offsets, field positions, reset values and key bytes for the
 * touch baseline configuration block.
 * Assumes the serial-bus slave delivers byte-wide register accesses on clk.
 */
// Functional notes
// - hold baseline when raw count sits below it by more than negative limit
// - count such low samples; at the reset count, load baseline with raw count
// - writing one to filter bit 7 resets all baselines; bit self-clears
// - filter bit 5 set drops samples taken during serial-bus traffic
// - filter bit 4 switches raw-count averaging on or off
// - average depth code 00/01/10/11 selects 2/4/8/16 samples
// - scan-order bit 0 sets sensor scan place; writable only in setup mode
// - single-button build omits the second sensor's scan, threshold, current registers
// - each sensor has an 8-bit touch threshold, range 3..255, default 64h; the code stores any written value, 0..2 included
// - excitation current write of zero becomes 10; 1..255 kept as written
// - key bytes 3Ch A5h 69h to guard register clear the guard state bit
// - key bytes 96h 5Ah C3h to guard register set the guard state bit
// - while locked, writes to slave-address register 7Ch are ignored
// - a new slave address takes effect only once access is locked again
// - guard register bit 0 reads 0 when unlocked, 1 when locked
// - small positive differences fill a bucket; full bucket bumps baseline, empties
`ifndef TOUCH_CONSTS_SVH
`define TOUCH_CONSTS_SVH

`define OFF_NEG_NOISE       8'h54
`define OFF_LOW_RESET       8'h55
`define OFF_FILTER          8'h56
`define OFF_SCAN0           8'h5c
`define OFF_SCAN1           8'h5d
`define OFF_THRESH0         8'h66
`define OFF_THRESH1         8'h67
`define OFF_CURRENT0        8'h70
`define OFF_CURRENT1        8'h71
`define OFF_GUARD           8'h79
`define OFF_SLAVE_ADDR      8'h7c

`define RST_NEG_NOISE       8'h0a
`define RST_LOW_RESET       8'h0a
`define RST_FILTER          8'h20
`define RST_SCAN            1'h0
`define RST_THRESH          8'h64
`define RST_CURRENT         8'h0a
`define RST_GUARD           1'h0
`define RST_SLAVE_ADDR      8'h00

`define FLT_FORCE_BIT       7
`define FLT_DROP_BIT        5
`define FLT_AVG_BIT         4
`define FLT_WRITE_MASK      8'h33

`define CURRENT_DEFAULT     8'h0a

`define KEY_UNLOCK_0        8'h3c
`define KEY_UNLOCK_1        8'ha5
`define KEY_UNLOCK_2        8'h69
`define KEY_LOCK_0          8'h96
`define KEY_LOCK_1          8'h5a
`define KEY_LOCK_2          8'hc3

`endif

//--- design/touch_pkg.sv
/*
 * Types shared by the touch configuration registers and the per-sensor
 * baseline tracker: guard sequence states and the packed state records.
 * Assumes at most two sensors and 16-bit raw counts.
 */
package touch_pkg;

    typedef enum logic [2:0] {
        seq_idle    = 3'b000,
        seq_unlock1 = 3'b001,
        seq_unlock2 = 3'b010,
        seq_lock1   = 3'b011,
        seq_lock2   = 3'b100
    } guard_seq_t;

    typedef struct packed {
        logic [19:0] sum;
        logic [4:0]  avg_cnt;
        logic [15:0] baseline;
        logic [15:0] bucket;
        logic [7:0]  low_cnt;
        logic [15:0] last_raw;
        logic        bus_seen;
        logic        primed;
    } tracker_state_t;

    typedef struct packed {
        logic [7:0]       neg_noise;
        logic [7:0]       low_reset;
        logic [7:0]       filter;
        logic             force_reset;
        logic [1:0]       scan;
        logic [1:0][7:0]  thresh;
        logic [1:0][7:0]  current;
        logic             guard;
        guard_seq_t       seq;
        logic [7:0]       addr_pending;
        logic [7:0]       addr_active;
        logic [7:0]       rdata;
    } regs_state_t;

endpackage

//--- design/track_if.sv
/*
 * Carrier between the register bank and one baseline tracker: shared
 * tracking settings go down, the tracked baseline comes back.
 * Assumes one instance per sensor, all on the same clock.
 */
`timescale 1ns/10ps
interface track_if;
    logic [7:0]  noise_limit;
    logic [7:0]  negative_noise_limit;
    logic [7:0]  low_sample_reset_count;
    logic [7:0]  bucket_limit;
    logic        force_baseline_reset;
    logic        bus_activity_sample_drop;
    logic        avg_enable;
    logic [1:0]  avg_order;
    logic [15:0] baseline;

    modport cfg (
        output noise_limit,
        output negative_noise_limit,
        output low_sample_reset_count,
        output bucket_limit,
        output force_baseline_reset,
        output bus_activity_sample_drop,
        output avg_enable,
        output avg_order,
        input  baseline
    );

    modport trk (
        input  noise_limit,
        input  negative_noise_limit,
        input  low_sample_reset_count,
        input  bucket_limit,
        input  force_baseline_reset,
        input  bus_activity_sample_drop,
        input  avg_enable,
        input  avg_order,
        output baseline
    );
endinterface

//--- design/baseline_tracker.sv
/*
 * Per-sensor raw-count filter and baseline tracker.
 * Assumes raw_count, sample_valid and bus_active come from logic on clk.
 */
`timescale 1ns/10ps
`include "touch_consts.svh"
module baseline_tracker (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // settings and baseline
    track_if.trk             tif,
    // sensing core samples
    input  wire logic [15:0] raw_count,
    input  wire logic        sample_valid,
    input  wire logic        bus_active
);
    touch_pkg::tracker_state_t s;
    touch_pkg::tracker_state_t next_s;

    assign tif.baseline = s.baseline;

    // filter, average, track
    always_comb begin
        logic [19:0] sum;
        logic [4:0]  depth;
        logic [15:0] filt;
        logic        filt_valid;
        logic [15:0] diff;
        sum        = 20'h00000;
        depth      = 5'h00;
        filt       = 16'h0000;
        filt_valid = 1'b0;
        diff       = 16'h0000;
        next_s     = s;
        // traffic seen since the last sample
        next_s.bus_seen = sample_valid ? 1'b0 : (s.bus_seen | bus_active);
        if (!tif.avg_enable) begin
            next_s.sum     = 20'h00000;
            next_s.avg_cnt = 5'h00;
        end
        if (tif.force_baseline_reset) begin
            next_s.baseline = s.last_raw;
            next_s.low_cnt  = 8'h00;
            next_s.bucket   = 16'h0000;
        end else if (sample_valid) begin
            if (tif.bus_activity_sample_drop && (s.bus_seen || bus_active)) begin
                filt_valid = 1'b0;
            end else if (tif.avg_enable) begin
                depth = 5'(5'h02 << tif.avg_order);
                sum   = s.sum + 20'(raw_count);
                if (s.avg_cnt + 5'h01 == depth) begin
                    filt           = 16'(sum >> ({1'b0, tif.avg_order} + 3'h1));
                    filt_valid     = 1'b1;
                    next_s.sum     = 20'h00000;
                    next_s.avg_cnt = 5'h00;
                end else begin
                    next_s.sum     = sum;
                    next_s.avg_cnt = s.avg_cnt + 5'h01;
                end
            end else begin
                filt       = raw_count;
                filt_valid = 1'b1;
            end
        end
        if (filt_valid) begin
            next_s.last_raw = filt;
            if (!s.primed) begin
                next_s.baseline = filt;
                next_s.primed   = 1'b1;
            end else if (filt < s.baseline) begin
                diff = s.baseline - filt;
                next_s.bucket = 16'h0000;
                if (diff > 16'(tif.negative_noise_limit)) begin
                    // baseline held while low
                    if (s.low_cnt + 8'h01 >= tif.low_sample_reset_count) begin
                        next_s.baseline = filt;
                        next_s.low_cnt  = 8'h00;
                    end else begin
                        next_s.low_cnt = s.low_cnt + 8'h01;
                    end
                end else begin
                    next_s.baseline = filt; // small dips are followed
                    next_s.low_cnt  = 8'h00;
                end
            end else begin
                diff = filt - s.baseline;
                next_s.low_cnt = 8'h00;
                if (diff < 16'(tif.noise_limit)) begin
                    if (s.bucket + diff >= 16'(tif.bucket_limit)) begin
                        next_s.baseline = s.baseline + 16'h0001;
                        next_s.bucket   = 16'h0000;
                    end else begin
                        next_s.bucket = s.bucket + diff;
                    end
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

//--- testbench/host_model.sv
/*
 * Host model: byte register accesses as one-cycle strobes.
 * Assumes its tasks are called from one process.
 */
`timescale 1ns/10ps
module host_model (
    // clock
    input  wire logic       clk,
    // register access strobes
    output logic            reg_write,
    output logic            reg_read,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    // idle bus
    initial begin
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // one-cycle strobe; address and data then show their inverse
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        #1;
        reg_write = wr;
        reg_read  = ~wr;
        reg_addr  = addr;
        reg_wdata = data;
        @(posedge clk);
        #1;
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_addr  = ~addr;
        reg_wdata = ~data;
    endtask

    // guard key, lock or unlock
    task automatic guard_key(input logic lock);
        access(1'b1, 8'h79, lock ? 8'h96 : 8'h3c);
        access(1'b1, 8'h79, lock ? 8'h5a : 8'ha5);
        access(1'b1, 8'h79, lock ? 8'hc3 : 8'h69);
    endtask
endmodule

//--- testbench/touch_regs_properties.sv
/*
 * Port checker bound to the touch register bank.
 * Assumes one clock clk and an asynchronous active-high reset rst.
 */
`timescale 1ns/10ps
module touch_regs_checker #(
    parameter int NUM_SENSORS = 2
) (
    // clock and reset
    input wire logic            clk,
    input wire logic            rst,
    // register access
    input wire logic            reg_write,
    input wire logic            reg_read,
    input wire logic [7:0]      reg_addr,
    input wire logic [7:0]      reg_wdata,
    input wire logic [7:0]      reg_rdata,
    input wire logic            setup_mode,
    // settings and slave address
    input wire logic [1:0]      scan_order,
    input wire logic [1:0][7:0] touch_threshold,
    input wire logic [1:0][7:0] excitation_current,
    input wire logic [7:0]      slave_address_register,
    input wire logic            address_guard_state
);
    // clk domain, off in reset
    default clocking dclk @(posedge clk);
    endclocking
    default disable iff (rst);
    // address of a write, zero when idle
    wire [7:0] wa = reg_write ? reg_addr : 8'h00;

    AST_THRESH0_WRITE: assert property (wa == 8'h66 |=> touch_threshold[0] == $past(reg_wdata))
        else $error("threshold 0 write lost");
    AST_THRESH1_WRITE: assert property (wa == 8'h67 && NUM_SENSORS > 1 |=> touch_threshold[1] == $past(reg_wdata))
        else $error("threshold 1 write lost");
    AST_CURRENT_ZERO: assert property (wa == 8'h70 && reg_wdata == 8'h00 |=> excitation_current[0] == 8'h0a)
        else $error("zero current kept");
    AST_CURRENT_KEEP: assert property (wa == 8'h70 && reg_wdata != 8'h00 |=> excitation_current[0] == $past(reg_wdata))
        else $error("current write lost");
    AST_SCAN_LOCKED: assert property (wa == 8'h5c && !setup_mode |=> $stable(scan_order[0]))
        else $error("scan write outside setup");
    AST_SCAN_SETUP: assert property (wa == 8'h5c && setup_mode |=> scan_order[0] == $past(reg_wdata[0]))
        else $error("scan order write lost");
    AST_UNLOCK_KEY: assert property (wa == 8'h79 && reg_wdata == 8'h3c ##2 wa == 8'h79 && reg_wdata == 8'ha5 ##2 wa == 8'h79 && reg_wdata == 8'h69 |=> !address_guard_state)
        else $error("unlock key ignored");
    AST_LOCK_KEY: assert property (wa == 8'h79 && reg_wdata == 8'h96 ##2 wa == 8'h79 && reg_wdata == 8'h5a ##2 wa == 8'h79 && reg_wdata == 8'hc3 |=> address_guard_state)
        else $error("lock key ignored");
    AST_ADDR_ON_LOCK: assert property ($changed(slave_address_register) |-> $rose(address_guard_state))
        else $error("address changed before relock");
    AST_GUARD_READ: assert property (reg_read && reg_addr == 8'h79 |=> reg_rdata == {7'h00, $past(address_guard_state)})
        else $error("guard read wrong");
    AST_FILTER_SELFCLEAR: assert property (reg_read && reg_addr == 8'h56 |=> reg_rdata[7:6] == 2'b00)
        else $error("force bit read set");
endmodule

bind touch_baseline_config_regs touch_regs_checker #(.NUM_SENSORS(NUM_SENSORS)) chk_u (
    .clk(clk), .rst(rst), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .setup_mode(setup_mode), .scan_order(scan_order),
    .touch_threshold(touch_threshold), .excitation_current(excitation_current),
    .slave_address_register(slave_address_register), .address_guard_state(address_guard_state)
);

//--- testbench/tb_top.sv
/*
 * Bench for the two-sensor touch register bank.
 * Assumes host_model drives the register strobes.
 */
`timescale 1ns/10ps
module tb_top;
    logic             clk = 1'b0;
    logic             rst;
    logic             reg_write, reg_read, setup_mode, bus_active, address_guard_state;
    logic [7:0]       reg_addr, reg_wdata, reg_rdata, slave_address_register, v;
    logic [1:0][15:0] raw_count, baseline;
    logic [1:0]       sample_valid, scan_order;
    logic [1:0][7:0]  touch_threshold, excitation_current;
    logic [15:0]      b;
    logic [7:0]       rd_q [$];
    int               err_total = 0, n_compared = 0, cycles = 0;
    logic [15:0]      rst_pair [12] = '{16'h540a, 16'h550a, 16'h5620, 16'h5c00, 16'h5d00, 16'h6664, 16'h6764,
                                        16'h700a, 16'h710a, 16'h7900, 16'h7c00, 16'h0000};

    // 100 MHz clock
    always #5 clk = ~clk;

    touch_baseline_config_regs #(.NUM_SENSORS(2)) dut_u (
        .clk(clk), .rst(rst), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .setup_mode(setup_mode), .bus_active(bus_active),
        .noise_limit(8'h14), .bucket_limit(8'h0a), .raw_count(raw_count), .sample_valid(sample_valid),
        .scan_order(scan_order), .touch_threshold(touch_threshold), .excitation_current(excitation_current),
        .baseline(baseline), .slave_address_register(slave_address_register),
        .address_guard_state(address_guard_state)
    );

    host_model host_u (.clk(clk), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    // compare and count
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // counts and verdict
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.access(1'b1, a, d);
    endtask

    // note expected data, then read
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rd_q.push_back(exp);
        host_u.access(1'b0, a, 8'h00);
    endtask

    // sample both sensors, check baselines
    task automatic smp(input logic [15:0] raw, input logic busy, input logic [15:0] exp);
        @(posedge clk);
        #1;
        raw_count    = {raw, raw};
        sample_valid = 2'b11;
        bus_active   = busy;
        @(posedge clk);
        #1;
        raw_count    = ~{raw, raw};
        sample_valid = 2'b00;
        bus_active   = 1'b0;
        check("baseline0", baseline[0], exp);
        check("baseline1", baseline[1], exp);
    endtask

    // oldest note against each read answer
    always @(posedge clk) begin
        if (reg_read === 1'b1) begin
            @(negedge clk);
            check("reg_rdata", {8'h00, reg_rdata}, {8'h00, rd_q.pop_front()});
        end
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end

    // main sequence
    initial begin
        void'($urandom(67));
        rst          = 1'b1;
        setup_mode   = 1'b0;
        bus_active   = 1'b0;
        raw_count    = '0;
        sample_valid = 2'b00;
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        foreach (rst_pair[i]) rd(rst_pair[i][15:8], rst_pair[i][7:0]);
        wr(8'h07, 8'h01);
        wr(8'h50, 8'ha0);
        wr(8'h51, 8'h00);
        wr(8'h55, 8'h03);
        wr(8'h56, 8'h00);
        smp(16'd1000, 1'b0, 16'd1000);
        repeat (2) smp(16'd900, 1'b0, 16'd1000);
        smp(16'd900, 1'b0, 16'd900);
        smp(16'd905, 1'b0, 16'd900);
        smp(16'd905, 1'b0, 16'd901);
        wr(8'h56, 8'h20);
        smp(16'd895, 1'b1, 16'd901);
        smp(16'd895, 1'b0, 16'd895);
        wr(8'h56, 8'h00);
        smp(16'd890, 1'b1, 16'd890);
        b = 16'd890;
        // per depth code: update on last sample only
        for (int code = 0; code < 4; code++) begin
            wr(8'h56, 8'h10 | 8'(code));
            repeat ((2 << code) - 1) smp(b - 16'd2, 1'b0, b);
            smp(b - 16'd2, 1'b0, b - 16'd2);
            b = b - 16'd2;
        end
        wr(8'h56, 8'h00);
        smp(16'd860, 1'b0, 16'd882);
        wr(8'h56, 8'h80);
        @(posedge clk);
        #1;
        check("baseline0", baseline[0], 16'd860);
        rd(8'h56, 8'h00);
        repeat (2) smp(16'd840, 1'b0, 16'd860);
        smp(16'd840, 1'b0, 16'd840);
        for (int i = 0; i < 2; i++) begin
            v = 8'($urandom);
            wr(8'h66 + 8'(i), v);
            rd(8'h66 + 8'(i), v);
            v = 8'(5 + $urandom % 251);
            wr(8'h70 + 8'(i), v);
            rd(8'h70 + 8'(i), v);
            wr(8'h70 + 8'(i), 8'h00);
            rd(8'h70 + 8'(i), 8'h0a);
        end
        wr(8'h5c, 8'h01);
        rd(8'h5c, 8'h00);
        setup_mode = 1'b1;
        wr(8'h5c, 8'h01);
        wr(8'h5d, 8'h01);
        check("scan_order", {14'h0, scan_order}, 16'h0003);
        setup_mode = 1'b0;
        v = 8'($urandom);
        wr(8'h7c, v);
        check("slv_addr", {8'h00, slave_address_register}, 16'h0000);
        rd(8'h7c, v);
        host_u.guard_key(1'b1);
        check("guard", {15'h0, address_guard_state}, 16'h0001);
        check("slv_addr", {8'h00, slave_address_register}, {8'h00, v});
        rd(8'h79, 8'h01);
        wr(8'h7c, ~v);
        rd(8'h7c, v);
        host_u.guard_key(1'b0);
        check("guard", {15'h0, address_guard_state}, 16'h0000);
        rd(8'h79, 8'h00);
        check("slv_addr", {8'h00, slave_address_register}, {8'h00, v});
        wr(8'h00, 8'h5a);
        rd(8'h00, 8'h00);
        wr(8'h56, 8'hff);
        rd(8'h56, 8'h33);
        repeat (3) @(posedge clk);
        check("rd_q", 16'(rd_q.size()), 16'h0000);
        summarize();
    end
endmodule
